// >>> logic/emt_modulo_reg.sv
`timescale 1ns/1ps
module emt_modulo_reg
   import emt_pkg::*;
(
   input wire logic clock_in,
   input wire logic init_in,
   input wire logic write_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] value_out
);

   // ***************************************************************
   // Interval compare value storage.
   // ***************************************************************
   logic [7:0] value_reg;

   always_ff @(posedge clock_in) begin
      if (init_in) begin
         value_reg <= MODULO_RESET;
      end else if (write_in) begin
         value_reg <= wdata_in;
      end
   end

   assign value_out = value_reg;

endmodule : emt_modulo_reg

// >>> logic/emt_modulo_timer.sv
// Summary of operation
// - Counts the selected basic clock in eight bits, compared with modulo.
// - Select code 00, 01, 10, 11 gives 100, 10, 2, 1 kHz.
// - Clock select field sits in control bits 1 and 0.
// - Control bit 3 runs the counter when 1, stops it when 0.
// - Writing 1 to control bit 2 clears the counter; 0 does nothing.
// - Counter reaching the modulo value raises an interrupt request.
// - The same match clears the counter so counting restarts at zero.
// - Software reads the count through the transfer buffer.
// - Software loads the modulo value through the transfer buffer.
// - Interrupt period equals modulo value times basic clock period.
// - Modulo is all ones after power, watchdog or clock stop reset.
// - Starting or stopping may cost up to one basic clock.
// - Clearing the counter may cost up to one basic clock.
// - Changing clock while running may cost one new clock period.
// - Match request wins over a simultaneous accept or counter clear, but not over a reset.
// - The counter clear bit always reads back as zero.
`timescale 1ns/1ps
module emt_modulo_timer
   import emt_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic watchdog_stack_reset_in,
   input wire logic clock_stop_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [3:0] reg_wdata_in,
   output logic [3:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire emt_buf_req_t buf_req_in,
   output logic [15:0] transfer_buffer_out,
   output logic buf_rvalid_out,
   input wire logic irq_accept_in,
   output logic irq_request_out,
   output logic match_pulse_out,
   output logic run_enable_out
);

   // ***************************************************************
   // Reset sources.
   // ***************************************************************
   wire logic init;

   assign init = rst_in || watchdog_stack_reset_in || clock_stop_in;

   // ***************************************************************
   // Address decode.
   // ***************************************************************
   function automatic logic hit(input logic [6:0] addr,
                                input logic [6:0] target);
      hit = (addr == target);
   endfunction : hit

   wire logic ctl_write;
   wire logic ctl_read;
   wire logic modulo_write;
   wire logic modulo_read;
   wire logic count_read;
   wire logic count_clear;

   assign ctl_write = reg_write_in && hit(reg_addr_in, ADDR_CONTROL);
   assign ctl_read = reg_read_in && hit(reg_addr_in, ADDR_CONTROL);
   assign modulo_write = buf_req_in.buffer_write_op &&
                         hit(buf_req_in.addr, ADDR_MODULO);
   assign modulo_read = buf_req_in.buffer_read_op &&
                        hit(buf_req_in.addr, ADDR_MODULO);
   assign count_read = buf_req_in.buffer_read_op &&
                       hit(buf_req_in.addr, ADDR_COUNT);
   assign count_clear = ctl_write && reg_wdata_in[CLEAR_BIT];

   // ***************************************************************
   // Control register.
   // ***************************************************************
   emt_ctl_t ctl_reg;
   emt_ctl_t ctl_next;

   always_comb begin
      ctl_next = ctl_reg;
      if (ctl_write) begin
         ctl_next.run_enable = reg_wdata_in[RUN_BIT];
         ctl_next.clock_select = {reg_wdata_in[SEL_HI_BIT],
                                  reg_wdata_in[SEL_LO_BIT]};
      end
   end

   always_ff @(posedge clock_in) begin
      if (init) begin
         ctl_reg <= emt_ctl_t'({CTRL_RESET[RUN_BIT], CTRL_RESET[SEL_HI_BIT],
                                CTRL_RESET[SEL_LO_BIT]});
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // ***************************************************************
   // Basic clock generation.
   // ***************************************************************
   wire logic basic_tick;

   // The divider chain runs free, so a start, clear or clock change
   // lands anywhere inside the current basic period.
   emt_tick_gen u_tick_gen (
      .clock_in (clock_in),
      .rst_in (init),
      .sel_in (ctl_reg.clock_select),
      .tick_out (basic_tick)
   );

   // ***************************************************************
   // Interval compare value.
   // ***************************************************************
   wire logic [7:0] compare_value;

   emt_modulo_reg u_modulo_reg (
      .clock_in (clock_in),
      .init_in (init),
      .write_in (modulo_write),
      .wdata_in (buf_req_in.data[7:0]),
      .value_out (compare_value)
   );

   // ***************************************************************
   // Running count and match.
   // ***************************************************************
   logic [7:0] running_count_reg;
   logic [7:0] running_count_next;
   wire logic count_step;
   wire logic [7:0] count_inc;
   wire logic match;

   assign count_step = basic_tick && ctl_reg.run_enable;
   assign count_inc = running_count_reg + 8'h01;
   assign match = count_step && (count_inc == compare_value);

   always_comb begin
      running_count_next = running_count_reg;
      if (count_clear) begin
         running_count_next = COUNT_RESET;
      end else if (match) begin
         running_count_next = COUNT_RESET;
      end else if (count_step) begin
         running_count_next = count_inc;
      end
   end

   always_ff @(posedge clock_in) begin
      if (init) begin
         running_count_reg <= COUNT_RESET;
      end else begin
         running_count_reg <= running_count_next;
      end
   end

   // ***************************************************************
   // Interrupt request.
   // ***************************************************************
   logic irq_reg;
   logic irq_next;
   logic match_reg;

   // A match in the cycle of an accept keeps the request.
   assign irq_next = match ? 1'b1 : (irq_accept_in ? 1'b0 : irq_reg);

   always_ff @(posedge clock_in) begin
      if (init) begin
         irq_reg <= 1'b0;
         match_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
         match_reg <= match;
      end
   end

   // ***************************************************************
   // Control register read.
   // ***************************************************************
   logic [3:0] reg_rdata_reg;
   logic reg_rvalid_reg;
   wire logic [3:0] ctl_view;

   assign ctl_view = {ctl_reg.run_enable, 1'b0,
                      ctl_reg.clock_select};

   always_ff @(posedge clock_in) begin
      if (init) begin
         reg_rdata_reg <= 4'h0;
         reg_rvalid_reg <= 1'b0;
      end else begin
         reg_rdata_reg <= ctl_read ? ctl_view : 4'h0;
         reg_rvalid_reg <= reg_read_in;
      end
   end

   // ***************************************************************
   // Transfer buffer read.
   // ***************************************************************
   logic [15:0] buf_rdata_reg;
   logic buf_rvalid_reg;
   wire logic [7:0] buf_view;

   assign buf_view = count_read ? running_count_reg :
                     (modulo_read ? compare_value : 8'h00);

   always_ff @(posedge clock_in) begin
      if (init) begin
         buf_rdata_reg <= 16'h0000;
         buf_rvalid_reg <= 1'b0;
      end else begin
         buf_rdata_reg <= {8'h00, buf_view};
         buf_rvalid_reg <= buf_req_in.buffer_read_op;
      end
   end

   // ***************************************************************
   // Outputs.
   // ***************************************************************
   assign reg_rdata_out = reg_rdata_reg;
   assign reg_rvalid_out = reg_rvalid_reg;
   assign transfer_buffer_out = buf_rdata_reg;
   assign buf_rvalid_out = buf_rvalid_reg;
   assign irq_request_out = irq_reg;
   assign match_pulse_out = match_reg;
   assign run_enable_out = ctl_reg.run_enable;

endmodule : emt_modulo_timer

// >>> logic/emt_pkg.sv
package emt_pkg;

   // ***************************************************************
   // Clock and basic clock timing.
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned PERIOD_100K_NS = 10000;
   localparam int unsigned PERIOD_10K_NS = 100000;
   localparam int unsigned PERIOD_2K_NS = 500000;
   localparam int unsigned PERIOD_1K_NS = 1000000;
   localparam int unsigned CYC_100K = (PERIOD_100K_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned RATIO_10K = PERIOD_10K_NS / PERIOD_100K_NS;
   localparam int unsigned RATIO_2K = PERIOD_2K_NS / PERIOD_10K_NS;
   localparam int unsigned RATIO_1K = PERIOD_1K_NS / PERIOD_2K_NS;
   localparam int unsigned NUM_STAGES = 3;
   localparam int unsigned STAGE_W = 4;

   // ***************************************************************
   // Widths.
   // ***************************************************************
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned CTRL_W = 4;
   localparam int unsigned COUNT_W = 8;
   localparam int unsigned BUF_W = 16;
   localparam int unsigned SEL_W = 2;

   // ***************************************************************
   // Addresses.
   // ***************************************************************
   localparam logic [6:0] ADDR_CONTROL = 7'h29;
   localparam logic [6:0] ADDR_MODULO = 7'h1E;
   localparam logic [6:0] ADDR_COUNT = 7'h1F;

   // ***************************************************************
   // Control register fields.
   // ***************************************************************
   localparam int unsigned RUN_BIT = 3;
   localparam int unsigned CLEAR_BIT = 2;
   localparam int unsigned SEL_HI_BIT = 1;
   localparam int unsigned SEL_LO_BIT = 0;
   localparam logic [1:0] SEL_100K = 2'h0;
   localparam logic [1:0] SEL_10K = 2'h1;
   localparam logic [1:0] SEL_2K = 2'h2;
   localparam logic [1:0] SEL_1K = 2'h3;

   // ***************************************************************
   // Reset values.
   // ***************************************************************
   localparam logic [7:0] MODULO_RESET = 8'hFF;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // ***************************************************************
   // Carriers.
   // ***************************************************************
   typedef struct packed {
      logic run_enable;
      logic [1:0] clock_select;
   } emt_ctl_t;

   typedef struct packed {
      logic [6:0] addr;
      logic buffer_write_op;
      logic buffer_read_op;
      logic [15:0] data;
   } emt_buf_req_t;

endpackage : emt_pkg

// >>> logic/emt_tick_gen.sv
`timescale 1ns/1ps
module emt_tick_gen
   import emt_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [1:0] sel_in,
   output logic tick_out
);

   // ***************************************************************
   // Free running divider chain.
   // ***************************************************************
   localparam int unsigned PRE_W = $clog2(CYC_100K);
   localparam int unsigned RATIO_TBL [NUM_STAGES] = '{RATIO_10K, RATIO_2K,
                                                       RATIO_1K};

   logic [PRE_W-1:0] pre_reg;
   logic [NUM_STAGES:0] stage_tick;
   logic tick_reg;

   assign stage_tick[0] = (pre_reg == PRE_W'(CYC_100K - 1));

   always_ff @(posedge clock_in) begin
      if (rst_in || stage_tick[0]) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + PRE_W'(1);
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_STAGES; g++) begin : g_stage
         logic [STAGE_W-1:0] cnt_reg;
         wire logic wrap;
         assign wrap = stage_tick[g] &&
                       (cnt_reg == STAGE_W'(RATIO_TBL[g] - 1));
         assign stage_tick[g+1] = wrap;
         always_ff @(posedge clock_in) begin
            if (rst_in || wrap) begin
               cnt_reg <= '0;
            end else if (stage_tick[g]) begin
               cnt_reg <= cnt_reg + STAGE_W'(1);
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Selected basic clock tick.
   // ***************************************************************
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= stage_tick[sel_in];
      end
   end

   assign tick_out = tick_reg;

endmodule : emt_tick_gen

// >>> tb/emt_modulo_timer_properties.sv
`timescale 1ns/1ps
// ***************************************************************
// Port checker.
// ***************************************************************
module emt_modulo_timer_properties
   import emt_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic watchdog_stack_reset_in,
   input wire logic clock_stop_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [3:0] reg_wdata_in,
   input wire logic [3:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire emt_buf_req_t buf_req_in,
   input wire logic [15:0] transfer_buffer_out,
   input wire logic buf_rvalid_out,
   input wire logic irq_accept_in,
   input wire logic irq_request_out,
   input wire logic match_pulse_out,
   input wire logic run_enable_out
);
   wire quiet = !watchdog_stack_reset_in && !clock_stop_in;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_ctl_wr;
      reg_write_in && reg_addr_in == ADDR_CONTROL && quiet;
   endsequence
   sequence s_accept;
      irq_accept_in && quiet ##1 !match_pulse_out;
   endsequence
   chk_run_follow: assert property (s_ctl_wr |=>
      run_enable_out == $past(reg_wdata_in[RUN_BIT]))
      else $error("run enable did not follow the write");
   chk_irq_set: assert property (match_pulse_out |-> irq_request_out)
      else $error("match without request");
   chk_irq_clear: assert property (s_accept |-> !irq_request_out)
      else $error("request not cleared by accept");
   chk_irq_hold: assert property (
      irq_request_out && !irq_accept_in && quiet |=> irq_request_out)
      else $error("request lost before accept");
   chk_match_gap: assert property (
      match_pulse_out |=> !match_pulse_out [*8])
      else $error("match repeated too soon");
   chk_stop_quiet: assert property (
      !run_enable_out [*2] |-> !match_pulse_out)
      else $error("match while stopped");
   chk_clear_rdzero: assert property (
      reg_rvalid_out |-> !reg_rdata_out[CLEAR_BIT])
      else $error("clear bit read as one");
   chk_rd_run: assert property (reg_read_in && quiet &&
      reg_addr_in == ADDR_CONTROL |=>
      reg_rdata_out[RUN_BIT] == $past(run_enable_out))
      else $error("run bit read back wrong");
   chk_get_valid: assert property (buf_req_in.buffer_read_op && quiet
      |=> buf_rvalid_out && transfer_buffer_out[15:8] == 8'h00)
      else $error("buffer read answer missing");
   chk_wd_reset: assert property (watchdog_stack_reset_in |=>
      !run_enable_out && !irq_request_out)
      else $error("watchdog reset left state");
endmodule : emt_modulo_timer_properties

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ***************************************************************
// Testbench.
// ***************************************************************
module tb_top
   import emt_pkg::*;
;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic watchdog_stack_reset_in = 1'b0;
   logic clock_stop_in = 1'b0;
   logic [6:0] reg_addr_in = 7'h00;
   logic reg_write_in = 1'b0;
   logic reg_read_in = 1'b0;
   logic [3:0] reg_wdata_in = 4'h0;
   logic [3:0] reg_rdata_out;
   logic reg_rvalid_out;
   emt_buf_req_t buf_req_in = '0;
   logic [15:0] transfer_buffer_out;
   logic buf_rvalid_out;
   logic irq_accept_in = 1'b0;
   logic irq_request_out;
   logic match_pulse_out;
   logic run_enable_out;
   int error_cnt = 0;
   int checked = 0;
   int n;
   logic [7:0] m;
   logic [3:0] reg_q[$];
   logic [15:0] buf_q[$];
   emt_modulo_timer dut_u (.clock_in, .rst_in, .watchdog_stack_reset_in,
      .clock_stop_in, .reg_addr_in, .reg_write_in, .reg_read_in,
      .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .buf_req_in,
      .transfer_buffer_out, .buf_rvalid_out, .irq_accept_in,
      .irq_request_out, .match_pulse_out, .run_enable_out);
   always #4 clock_in = ~clock_in;
   task check(input string name, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task stop_test;
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   // Write, or read with the expected answer noted.
   task reg_op(input logic [6:0] a, input logic wr, input logic [3:0] d);
      if (!wr) begin
         reg_q.push_back(d);
      end
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_write_in <= wr;
      reg_read_in <= !wr;
      reg_wdata_in <= d;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
      reg_read_in <= 1'b0;
   endtask : reg_op
   task buf_op(input logic [6:0] a, input logic wr, input logic [15:0] d);
      if (!wr) begin
         buf_q.push_back(d);
      end
      @(posedge clock_in);
      buf_req_in <= '{addr: a, buffer_write_op: wr, buffer_read_op: !wr,
         data: d};
      @(posedge clock_in);
      buf_req_in <= '0;
   endtask : buf_op
   task wait_match;
      n = 0;
      do begin
         @(negedge clock_in);
         n++;
      end while (match_pulse_out !== 1'b1 && n < 40000);
      if (match_pulse_out !== 1'b1) begin
         error_cnt++;
      end
   endtask : wait_match
   always @(negedge clock_in) begin
      if (reg_rvalid_out === 1'b1) begin
         check("reg_rd", 16'(reg_rdata_out), 16'(reg_q.pop_front()));
      end
      if (buf_rvalid_out === 1'b1) begin
         check("xfer_buf", transfer_buffer_out, buf_q.pop_front());
      end
   end
   initial begin
      repeat (90000) @(posedge clock_in);
      error_cnt++;
      stop_test();
   end
   initial begin
      n = $urandom(25);
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      reg_op(ADDR_CONTROL, 1'b0, CTRL_RESET);
      buf_op(ADDR_MODULO, 1'b0, {8'h00, MODULO_RESET});
      buf_op(ADDR_COUNT, 1'b0, {8'h00, COUNT_RESET});
      reg_op(7'h2A, 1'b0, 4'h0);
      buf_op(7'h20, 1'b1, 16'hFFAB);
      buf_op(ADDR_COUNT, 1'b0, 16'h0000);
      buf_op(7'h20, 1'b0, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         reg_op(ADDR_CONTROL, 1'b1, {2'b01, 2'(i)});
         reg_op(ADDR_CONTROL, 1'b0, {2'b00, 2'(i)});
      end
      m = 8'(2 + $urandom % 3);
      buf_op(ADDR_MODULO, 1'b1, {8'hA5, m});
      buf_op(ADDR_MODULO, 1'b0, {8'h00, m});
      reg_op(ADDR_CONTROL, 1'b1, 4'h8);
      wait_match();
      wait_match();
      check("period_100k", 16'(n), 16'(m * CYC_100K));
      check("irq_set", 16'(irq_request_out), 16'h0001);
      buf_op(ADDR_COUNT, 1'b0, 16'h0000);
      @(posedge clock_in);
      irq_accept_in <= 1'b1;
      @(posedge clock_in);
      irq_accept_in <= 1'b0;
      @(negedge clock_in);
      check("irq_clear", 16'(irq_request_out), 16'h0000);
      buf_op(ADDR_MODULO, 1'b1, 16'h0001);
      reg_op(ADDR_CONTROL, 1'b1, 4'h9);
      wait_match();
      wait_match();
      check("period_10k", 16'(n), 16'(CYC_100K * RATIO_10K));
      buf_op(ADDR_MODULO, 1'b1, 16'h000A);
      reg_op(ADDR_CONTROL, 1'b1, 4'h8);
      wait_match();
      repeat (3 * CYC_100K + 600) @(negedge clock_in);
      buf_op(ADDR_COUNT, 1'b0, 16'h0003);
      reg_op(ADDR_CONTROL, 1'b1, 4'h8);
      buf_op(ADDR_COUNT, 1'b0, 16'h0003);
      reg_op(ADDR_CONTROL, 1'b1, 4'hC);
      buf_op(ADDR_COUNT, 1'b0, 16'h0000);
      reg_op(ADDR_CONTROL, 1'b1, 4'h0);
      repeat (5 * CYC_100K) @(negedge clock_in);
      buf_op(ADDR_COUNT, 1'b0, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         buf_op(ADDR_MODULO, 1'b1, 16'h005A);
         reg_op(ADDR_CONTROL, 1'b1, 4'h9);
         @(posedge clock_in);
         watchdog_stack_reset_in <= (k == 0);
         clock_stop_in <= (k == 1);
         @(posedge clock_in);
         watchdog_stack_reset_in <= 1'b0;
         clock_stop_in <= 1'b0;
         buf_op(ADDR_MODULO, 1'b0, {8'h00, MODULO_RESET});
         reg_op(ADDR_CONTROL, 1'b0, CTRL_RESET);
      end
      repeat (3) @(negedge clock_in);
      check("pending", 16'(reg_q.size() + buf_q.size()), 16'h0000);
      stop_test();
   end
endmodule : tb_top
bind emt_modulo_timer emt_modulo_timer_properties chk_u (.clock_in, .rst_in,
   .watchdog_stack_reset_in, .clock_stop_in, .reg_addr_in, .reg_write_in,
   .reg_read_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .buf_req_in,
   .transfer_buffer_out, .buf_rvalid_out, .irq_accept_in, .irq_request_out,
   .match_pulse_out, .run_enable_out);
